// *** hw/pbf_top.sv ***
// Receive framer that builds the buffer status word, count and control byte,
// plus transmit control byte decoding, with AXI4-Lite control registers.
// Assumes MAC byte stream and memory writes are in the MCLK domain.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module pbf_top (
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        RX_START,
  input  wire logic        RX_BYTE_VALID,
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic        RX_END,
  input  wire logic        RX_ERR,
  input  wire logic        RX_NIBBLE_ODD,
  input  wire logic [2:0]  RX_BIT_REM,
  output logic             MEM_WE,
  output logic [10:0]      MEM_ADDR,
  output logic [15:0]      MEM_WDATA,
  output logic             MEDIA_SELECT_OUTPUT,
  output logic             RX_ACCEPT,
  input  wire logic [15:0] TX_COUNT_WORD,
  input  wire logic [7:0]  TX_CTRL_BYTE,
  input  wire logic        TX_DONE,
  input  wire logic [15:0] TX_STATUS,
  output logic [10:0]      TX_SEND_LEN,
  output logic             TX_APPEND_CHECK
);
  logic        suppress_check_append_ff;
  logic [63:0] mcast_table_ff;
  logic        tx_stat_pend_ff;
  logic [15:0] tx_stat_ff;
  logic        rx_mem_busy;
  logic        aw_got_ff, w_got_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  pbf_pkg::pbf_rx_state_t rx_state_ff;
  logic [31:0] crc_ff, crc_nxt;
  logic [10:0] rx_cnt_ff;
  logic [31:0] dst_crc_ff;
  logic        group_ff, bcast_ff, err_seen_ff;
  logic [7:0]  low_byte_ff;
  logic [1:0]  done_step_ff;
  logic [15:0] status_word;
  logic [5:0]  hash;
  logic        hash_hit;
  logic        bad_check;
  logic        align_err;
  logic [10:0] words_total;

  pbf_crc u_crc (
    .crc_in  (crc_ff),
    .data    (RX_BYTE),
    .crc_out (crc_nxt)
  );

  // Write channel: address and data are taken independently, in either order.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      AWREADY    <= 1'b0;
      WREADY     <= 1'b0;
      BVALID     <= 1'b0;
      BRESP      <= pbf_pkg::PBF_RESP_OKAY;
    end else begin
      AWREADY <= !aw_got_ff && !AWREADY && !BVALID;
      WREADY  <= !w_got_ff && !WREADY && !BVALID;
      if (AWVALID && AWREADY) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= AWADDR;
        AWREADY    <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= WDATA;
        w_strb_ff <= WSTRB;
        WREADY    <= 1'b0;
      end
      if (aw_got_ff && w_got_ff && !BVALID) begin
        BVALID    <= 1'b1;
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        if (aw_addr_ff == pbf_pkg::PBF_REG_CTRL || aw_addr_ff == pbf_pkg::PBF_REG_MT_LO ||
            aw_addr_ff == pbf_pkg::PBF_REG_MT_HI) begin
          BRESP <= pbf_pkg::PBF_RESP_OKAY;
        end else begin
          BRESP <= pbf_pkg::PBF_RESP_SLVERR;
        end
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Register stores; writes land in the cycle the response is raised.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      suppress_check_append_ff <= 1'b0;
      MEDIA_SELECT_OUTPUT      <= 1'b0;
      mcast_table_ff           <= 64'h0000000000000000;
    end else if (aw_got_ff && w_got_ff && !BVALID) begin
      if (aw_addr_ff == pbf_pkg::PBF_REG_CTRL && w_strb_ff[0]) begin
        suppress_check_append_ff <= w_data_ff[pbf_pkg::PBF_CTRL_NOAPP];
        MEDIA_SELECT_OUTPUT      <= w_data_ff[pbf_pkg::PBF_CTRL_MEDIA]; // RL23
      end
      for (int b = 0; b < 4; b++) begin
        if (w_strb_ff[b] && aw_addr_ff == pbf_pkg::PBF_REG_MT_LO) begin
          mcast_table_ff[b*8 +: 8] <= w_data_ff[b*8 +: 8];
        end
        if (w_strb_ff[b] && aw_addr_ff == pbf_pkg::PBF_REG_MT_HI) begin
          mcast_table_ff[32 + b*8 +: 8] <= w_data_ff[b*8 +: 8];
        end
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= pbf_pkg::PBF_RESP_OKAY;
    end else begin
      ARREADY <= !ARREADY && !RVALID;
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RRESP   <= pbf_pkg::PBF_RESP_OKAY;
        case (ARADDR)
          pbf_pkg::PBF_REG_CTRL:   RDATA <= {30'h0, MEDIA_SELECT_OUTPUT, suppress_check_append_ff};
          pbf_pkg::PBF_REG_MT_LO:  RDATA <= mcast_table_ff[31:0];
          pbf_pkg::PBF_REG_MT_HI:  RDATA <= mcast_table_ff[63:32];
          // Receive status lives only in the packet, so its offset decodes as unmapped.
          pbf_pkg::PBF_REG_TXINFO: RDATA <= {19'h0, TX_APPEND_CHECK, 1'b0, TX_SEND_LEN};
          default: begin
            RDATA <= 32'h00000000;
            RRESP <= pbf_pkg::PBF_RESP_SLVERR;
          end
        endcase
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // Transmit decode: the packet body is software's, sent as stored, addresses included.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_SEND_LEN     <= 11'h000;
      TX_APPEND_CHECK <= 1'b1;
    end else begin
      // Count minus header and control word gives even data bytes; odd flag adds one.
      TX_SEND_LEN <= {TX_COUNT_WORD[10:1], 1'b0} - pbf_pkg::PBF_OVERHEAD // RL5 RL1 RL6 RL7
                     + {10'h0, TX_CTRL_BYTE[pbf_pkg::PBF_TX_ODD_BIT]}; // RL9
      TX_APPEND_CHECK <= !suppress_check_append_ff || // RL10
                         TX_CTRL_BYTE[pbf_pkg::PBF_TX_APPEND_BIT]; // RL24
    end
  end

  // The checksum register runs bit-reversed, so the six top checksum bits are
  // its six low bits taken in reverse order.
  assign hash        = {dst_crc_ff[0], dst_crc_ff[1], dst_crc_ff[2],
                        dst_crc_ff[3], dst_crc_ff[4], dst_crc_ff[5]}; // RL17
  assign hash_hit    = mcast_table_ff[{hash[5:3], hash[2:0]}]; // RL18
  assign bad_check   = (crc_ff != pbf_pkg::PBF_CRC_RESIDUE) || err_seen_ff; // RL15
  assign align_err   = bad_check && (MEDIA_SELECT_OUTPUT ? RX_NIBBLE_ODD // RL13
                                                         : (RX_BIT_REM != 3'h0)); // RL14
  assign words_total = (rx_cnt_ff + pbf_pkg::PBF_OVERHEAD) >> 1;
  assign status_word = {align_err, bcast_ff, bad_check, rx_cnt_ff[0], // RL20
                        rx_cnt_ff > pbf_pkg::PBF_WIRE_MAX, // RL16
                        rx_cnt_ff < pbf_pkg::PBF_WIRE_MIN,
                        3'h0, hash, group_ff};

  // The receive engine owns the write port; a transmit status waits for a free cycle.
  assign rx_mem_busy = (rx_state_ff == pbf_pkg::PBF_RX_DONE) ||
                       (rx_state_ff == pbf_pkg::PBF_RX_DATA && RX_BYTE_VALID &&
                        rx_cnt_ff < pbf_pkg::PBF_MAX_DATA && rx_cnt_ff[0]);

  // Transmit completion status is held until it can go into the packet's first word.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_stat_pend_ff <= 1'b0;
      tx_stat_ff      <= 16'h0000;
    end else if (TX_DONE) begin
      tx_stat_pend_ff <= 1'b1; // RL21
      tx_stat_ff      <= TX_STATUS;
    end else if (!rx_mem_busy) begin
      tx_stat_pend_ff <= 1'b0;
    end
  end

  // Receive engine: data words first, then control byte, count and status last.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_state_ff    <= pbf_pkg::PBF_RX_IDLE;
      crc_ff         <= pbf_pkg::PBF_CRC_INIT;
      dst_crc_ff     <= pbf_pkg::PBF_CRC_INIT;
      rx_cnt_ff      <= 11'h000;
      group_ff       <= 1'b0;
      bcast_ff       <= 1'b0;
      err_seen_ff    <= 1'b0;
      low_byte_ff    <= 8'h00;
      done_step_ff   <= 2'h0;
      MEM_WE         <= 1'b0;
      MEM_ADDR       <= 11'h000;
      MEM_WDATA      <= 16'h0000;
      RX_ACCEPT      <= 1'b0;
    end else begin
      MEM_WE <= 1'b0;
      case (rx_state_ff)
        pbf_pkg::PBF_RX_IDLE: begin
          if (RX_START) begin
            rx_state_ff <= pbf_pkg::PBF_RX_DATA;
            crc_ff      <= pbf_pkg::PBF_CRC_INIT;
            rx_cnt_ff   <= 11'h000;
            bcast_ff    <= 1'b1;
            group_ff    <= 1'b0;
            err_seen_ff <= 1'b0;
            RX_ACCEPT   <= 1'b0;
          end
        end
        pbf_pkg::PBF_RX_DATA: begin
          if (RX_ERR) begin
            err_seen_ff <= 1'b1; // RL15
          end
          if (RX_BYTE_VALID && rx_cnt_ff < pbf_pkg::PBF_MAX_DATA) begin // RL2
            crc_ff    <= crc_nxt;
            rx_cnt_ff <= rx_cnt_ff + 11'h001;
            if (rx_cnt_ff < {8'h0, pbf_pkg::PBF_ADDR_LEN}) begin
              bcast_ff <= bcast_ff && (RX_BYTE == 8'hff); // RL20
              if (rx_cnt_ff == 11'h000) begin
                group_ff <= RX_BYTE[0]; // RL25
              end
            end
            if (rx_cnt_ff == {8'h0, pbf_pkg::PBF_ADDR_LEN} - 11'h001) begin
              dst_crc_ff <= crc_nxt;
            end
            if (rx_cnt_ff[0]) begin
              MEM_WE    <= 1'b1;
              MEM_ADDR  <= pbf_pkg::PBF_DATA_OFS + {rx_cnt_ff[10:1], 1'b0};
              MEM_WDATA <= {RX_BYTE, low_byte_ff};
            end else begin
              low_byte_ff <= RX_BYTE;
            end
          end
          if (RX_END) begin
            rx_state_ff  <= pbf_pkg::PBF_RX_DONE;
            done_step_ff <= 2'h0;
          end
        end
        pbf_pkg::PBF_RX_DONE: begin
          done_step_ff <= done_step_ff + 2'h1;
          MEM_WE       <= 1'b1;
          case (done_step_ff)
            2'h0: begin
              // Control word holds a leftover odd byte low and the control byte high.
              MEM_ADDR  <= pbf_pkg::PBF_DATA_OFS + {rx_cnt_ff[10:1], 1'b0};
              MEM_WDATA <= {pbf_pkg::PBF_RX_CTRL_BASE | // RL11 RL22
                            (rx_cnt_ff[0] ? pbf_pkg::PBF_RX_CTRL_ODD : 8'h00),
                            rx_cnt_ff[0] ? low_byte_ff : 8'h00};
            end
            2'h1: begin
              MEM_ADDR  <= 11'h002;
              MEM_WDATA <= {4'h0, words_total, 1'b0}; // RL3 RL4
            end
            default: begin
              MEM_ADDR       <= 11'h000;
              MEM_WDATA      <= status_word; // RL12 RL1
              RX_ACCEPT      <= group_ff && hash_hit; // RL19
              rx_state_ff    <= pbf_pkg::PBF_RX_IDLE;
            end
          endcase
        end
        default: begin
          rx_state_ff <= pbf_pkg::PBF_RX_IDLE;
        end
      endcase
      if (tx_stat_pend_ff && !rx_mem_busy) begin
        MEM_WE    <= 1'b1;
        MEM_ADDR  <= 11'h000;
        MEM_WDATA <= tx_stat_ff; // RL21
      end
    end
  end
endmodule // pbf_top

// *** hw/pbf_pkg.sv ***
// Constants, field layouts, register offsets and states for the packet buffer framer.
// Assumes one clock domain; the host reaches control registers over AXI4-Lite, status through the packet buffer.
// Summary of operation
// RL1 - Packet: status word, byte count, then data.
// RL2 - Data starts at offset four, at most 2043.
// RL3 - Byte count halved equals total words.
// RL4 - Receive count even; odd flag marks last byte.
// RL5 - Transmit count bit zero read as zero.
// RL6 - Software supplies all transmit bytes, addresses too.
// RL7 - Length/type field passes through uninterpreted.
// RL8 - Software builds transmit control byte correctly.
// RL9 - Odd flag decides whether last byte sent.
// RL10 - Per-packet append flag honoured only when suppressing.
// RL11 - Receive control byte: bit six, odd flag.
// RL12 - Receive status written to memory, not register.
// RL13 - Nibble mode: odd nibbles with check fail.
// RL14 - Serial mode: bits not octet multiple, fail.
// RL15 - Check fail on bad sequence or receive error.
// RL16 - Flag oversize above 1518, undersize below 64.
// RL17 - Hash is six top checksum bits of address.
// RL18 - Hash bits select table byte and bit.
// RL19 - Group address with set table bit accepted.
// RL20 - Flag odd length frames and broadcast frames.
// RL21 - Device writes transmit status on completion.
// RL22 - Receive side writes status, count, data, control.
// RL23 - Media select bit chooses serial or nibble.
// RL24 - Suppression set: no check unless byte requests.
// RL25 - Group address when first octet bit zero set.
package pbf_pkg;
  localparam logic [10:0] PBF_DATA_OFS      = 11'h004;
  localparam logic [10:0] PBF_MAX_DATA      = 11'h7fb;
  localparam logic [10:0] PBF_WIRE_MAX      = 11'h5ee;
  localparam logic [10:0] PBF_WIRE_MIN      = 11'h040;
  localparam logic [10:0] PBF_OVERHEAD      = 11'h006;
  localparam int          PBF_TX_ODD_BIT    = 5;
  localparam int          PBF_TX_APPEND_BIT = 4;
  localparam logic [7:0]  PBF_RX_CTRL_BASE  = 8'h40;
  localparam logic [7:0]  PBF_RX_CTRL_ODD   = 8'h20;
  localparam int          PBF_ST_ALIGN      = 15;
  localparam int          PBF_ST_BCAST      = 14;
  localparam int          PBF_ST_BADCHK     = 13;
  localparam int          PBF_ST_ODD        = 12;
  localparam int          PBF_ST_LONG       = 11;
  localparam int          PBF_ST_SHORT      = 10;
  localparam int          PBF_ST_GROUP      = 0;
  localparam int          PBF_HASH_LSB      = 1;
  localparam logic [31:0] PBF_CRC_INIT      = 32'hffffffff;
  localparam logic [31:0] PBF_CRC_POLY      = 32'hedb88320;
  localparam logic [31:0] PBF_CRC_RESIDUE   = 32'hdebb20e3;
  localparam logic [2:0]  PBF_ADDR_LEN      = 3'h6;
  localparam logic [7:0]  PBF_REG_CTRL      = 8'h00;
  localparam logic [7:0]  PBF_REG_MT_LO     = 8'h04;
  localparam logic [7:0]  PBF_REG_MT_HI     = 8'h08;
  localparam logic [7:0]  PBF_REG_RXSTAT    = 8'h0c;
  localparam logic [7:0]  PBF_REG_TXINFO    = 8'h10;
  localparam int          PBF_CTRL_NOAPP    = 0;
  localparam int          PBF_CTRL_MEDIA    = 1;
  localparam logic [1:0]  PBF_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  PBF_RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {
    PBF_RX_IDLE = 2'b00,
    PBF_RX_DATA = 2'b01,
    PBF_RX_DONE = 2'b10
  } pbf_rx_state_t;
endpackage

// *** hw/pbf_crc.sv ***
// Bytewise Ethernet checksum step, reflected polynomial.
// Assumes the caller holds the running value and seeds it.
`timescale 1ns/100ps
module pbf_crc (
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc_out
);
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ pbf_pkg::PBF_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end
endmodule // pbf_crc

// *** tb/pbf_top_properties.sv ***
// Port checker for the packet buffer framer, bound onto pbf_top.
// Assumes the single MCLK domain and the active-low RST_B of the top module.
`timescale 1ns/100ps
module pbf_top_properties (
  input wire logic        MCLK,
  input wire logic        RST_B,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic        MEM_WE,
  input wire logic [10:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  input wire logic [15:0] TX_COUNT_WORD,
  input wire logic [7:0]  TX_CTRL_BYTE,
  input wire logic [10:0] TX_SEND_LEN
);
  wire logic       st_wr   = MEM_WE && MEM_ADDR == 11'h000;
  wire logic       cnt_wr  = MEM_WE && MEM_ADDR == 11'h002;
  wire logic [9:0] tx_half = TX_COUNT_WORD[10:1];
  wire logic       tx_odd  = TX_CTRL_BYTE[5];
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  chk_bvalid_hold: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read answer changed early");
  chk_bresp_timing: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write response late");
  chk_count_even: assert property (cnt_wr |-> !MEM_WDATA[0])
    else $error("odd receive byte count");
  chk_status_follows: assert property (cnt_wr |=> st_wr)
    else $error("status word not after count");
  chk_ctrl_precedes: assert property (cnt_wr |-> $past(MEM_WE) && $past(MEM_ADDR) > 11'h003)
    else $error("control word not before count");
  chk_align_cause: assert property (st_wr && $past(cnt_wr) && MEM_WDATA[15] |-> MEM_WDATA[13])
    else $error("alignment flag without check failure");
  chk_data_span: assert property (MEM_WE |-> MEM_ADDR <= 11'h7fe && !MEM_ADDR[0])
    else $error("buffer write outside packet");
  // Small counts would wrap below zero, so only counts of six bytes and up are judged.
  chk_tx_length: assert property ($past(RST_B) && $past(tx_half) > 10'h002 |->
    TX_SEND_LEN == {$past(tx_half), 1'b0} - 11'h006 + 11'($past(tx_odd)))
    else $error("transmit length wrong");
  cover property (st_wr && MEM_WDATA[15]);
  cover property (st_wr && MEM_WDATA[14]);
  cover property (RVALID && RREADY);
endmodule // pbf_top_properties

bind pbf_top pbf_top_properties pbf_top_properties_i (.MCLK, .RST_B, .AWVALID, .AWREADY,
  .WVALID, .WREADY, .BVALID, .BREADY, .RVALID, .RREADY, .RDATA, .MEM_WE, .MEM_ADDR,
  .MEM_WDATA, .TX_COUNT_WORD, .TX_CTRL_BYTE, .TX_SEND_LEN);

// *** tb/pbf_buf_mem.sv ***
// Packet buffer memory that takes the framer's word writes.
// Assumes word-aligned byte addresses in the MCLK domain.
`timescale 1ns/100ps
module pbf_buf_mem (
  input  wire logic        clk,
  input  wire logic        we,
  input  wire logic [10:0] addr,
  input  wire logic [15:0] wdata,
  output int               stat_cnt
);
  logic [15:0] words [0:1023];
  initial stat_cnt = 0;
  always @(posedge clk) begin
    if (we) begin
      words[addr[10:1]] <= wdata;
      if (addr == 11'h000) stat_cnt <= stat_cnt + 1;
    end
  end
endmodule // pbf_buf_mem

// *** tb/tb_top.sv ***
// Self-checking bench for pbf_top with a buffer memory on its write side.
// Assumes the framer answers within a few cycles; a watchdog cuts hangs.
`timescale 1ns/100ps
module tb_top;
  logic        MCLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, TX_DONE;
  logic [7:0]  AWADDR, ARADDR, RX_BYTE, TX_CTRL_BYTE;
  logic [31:0] WDATA;
  logic [3:0]  WSTRB;
  logic        RX_START, RX_BYTE_VALID, RX_END, RX_ERR, RX_NIBBLE_ODD;
  logic [2:0]  RX_BIT_REM;
  logic [15:0] TX_COUNT_WORD, TX_STATUS, MEM_WDATA;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, MEM_WE;
  logic        MEDIA_SELECT_OUTPUT, RX_ACCEPT, TX_APPEND_CHECK;
  logic [1:0]  BRESP, RRESP;
  logic [31:0] RDATA;
  logic [10:0] MEM_ADDR, TX_SEND_LEN;
  int          fail_count, checks, sc;
  pbf_top pbf_top_i (.*);
  pbf_buf_mem pbf_buf_mem_i (.clk(MCLK), .we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA),
    .stat_cnt(sc));
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d, fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    AWADDR <= a; WDATA <= d; WSTRB <= s;
    AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
    forever begin
      @(posedge MCLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    r = BRESP;
    BREADY <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
    forever begin
      @(posedge MCLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    d = RDATA; r = RRESP;
    RREADY <= 1'b0;
    @(posedge MCLK);
  endtask
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h0, d};
    repeat (8) c = c[0] ? (c >> 1) ^ pbf_pkg::PBF_CRC_POLY : c >> 1;
    return c;
  endfunction
  // e[0] raises the receive-error input mid frame, e[1] spoils the last check byte.
  task automatic frame(input int n, input logic [7:0] d0, input logic [1:0] e,
                       input logic [2:0] rem, input logic nib, input logic [5:0] hi,
                       input logic grp);
    logic [31:0] c;
    logic [7:0]  b, x;
    logic [15:0] w;
    int          s0;
    c = pbf_pkg::PBF_CRC_INIT; s0 = sc;
    RX_BIT_REM <= rem; RX_NIBBLE_ODD <= nib; RX_START <= 1'b1;
    @(posedge MCLK);
    RX_START <= 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i < n - 4) begin
        b = (i < 6) ? ((i == 0 || d0 == 8'hff) ? d0 : 8'h00) : i[7:0];
        c = crc8(c, b);
      end else b = ~c[8 * (i - n + 4) +: 8];
      RX_BYTE <= b ^ {7'h0, e[1] && i == n - 1}; RX_BYTE_VALID <= 1'b1;
      RX_ERR <= e[0] && i == 10;
      @(posedge MCLK);
    end
    RX_BYTE_VALID <= 1'b0; RX_ERR <= 1'b0; RX_END <= 1'b1;
    @(posedge MCLK);
    RX_END <= 1'b0;
    for (int i = 0; i < 20 && sc == s0; i++) @(posedge MCLK);
    w = pbf_buf_mem_i.words[0];
    cmp("status flags", {hi, grp}, {w[15:10], w[0]});
    cmp("byte count", 32'((n + 6) & ~1), pbf_buf_mem_i.words[1]);
    w = pbf_buf_mem_i.words[8];
    cmp("type field", 16'h0d0c, w);
    w = pbf_buf_mem_i.words[(n + 4) / 2];
    x = n[0] ? 8'h60 : 8'h40;
    cmp("control byte", x, w[15:8]);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axr(pbf_pkg::PBF_REG_CTRL, d, r);
    cmp("ctrl reset", 32'h0, d);
    cmp("media reset", 1'b0, MEDIA_SELECT_OUTPUT);
    cmp("append reset", 1'b1, TX_APPEND_CHECK);
    axw(pbf_pkg::PBF_REG_MT_LO, 32'h0, 4'hf, r);
    axw(pbf_pkg::PBF_REG_MT_LO, 32'hffffffff, 4'h2, r);
    axr(pbf_pkg::PBF_REG_MT_LO, d, r);
    cmp("table strobe", 32'h0000ff00, d);
    axr(8'h14, d, r);
    cmp("unmapped resp", pbf_pkg::PBF_RESP_SLVERR, r);
    cmp("unmapped data", 32'h0, d);
    axw(pbf_pkg::PBF_REG_RXSTAT, 32'h1, 4'hf, r);
    cmp("status write resp", pbf_pkg::PBF_RESP_SLVERR, r);
    axr(pbf_pkg::PBF_REG_RXSTAT, d, r);
    cmp("status read resp", pbf_pkg::PBF_RESP_SLVERR, r);
  endtask
  task automatic t_rx;
    logic [1:0] r;
    axw(pbf_pkg::PBF_REG_MT_LO, 32'hffffffff, 4'hf, r);
    axw(pbf_pkg::PBF_REG_MT_HI, 32'hffffffff, 4'hf, r);
    frame(64, 8'hff, 2'h0, 3'h0, 1'b0, 6'b010000, 1'b1);
    axw(pbf_pkg::PBF_REG_MT_LO, 32'h0, 4'hf, r);
    axw(pbf_pkg::PBF_REG_MT_HI, 32'h00000080, 4'hf, r);
    frame(65, 8'h01, 2'h0, 3'h0, 1'b0, 6'b000100, 1'b1);
    cmp("hash", 6'h27, pbf_buf_mem_i.words[0][6:1]);
    cmp("accept", 1'b1, RX_ACCEPT);
    frame(65, 8'hed, 2'h0, 3'h0, 1'b0, 6'b000100, 1'b1);
    cmp("hash", 6'h00, pbf_buf_mem_i.words[0][6:1]);
    cmp("no accept", 1'b0, RX_ACCEPT);
    frame(1519, 8'h00, 2'h0, 3'h0, 1'b0, 6'b000110, 1'b0);
    axw(pbf_pkg::PBF_REG_CTRL, 32'h2, 4'hf, r);
    cmp("media nibble", 1'b1, MEDIA_SELECT_OUTPUT);
    frame(20, 8'h00, 2'h1, 3'h0, 1'b1, 6'b101001, 1'b0);
    frame(20, 8'h00, 2'h0, 3'h0, 1'b1, 6'b000001, 1'b0);
    axw(pbf_pkg::PBF_REG_CTRL, 32'h0, 4'hf, r);
    frame(20, 8'h00, 2'h2, 3'h3, 1'b1, 6'b101001, 1'b0);
    frame(20, 8'h00, 2'h2, 3'h0, 1'b1, 6'b001001, 1'b0);
  endtask
  task automatic t_tx;
    logic [7:0] cb [4] = '{8'h20, 8'h00, 8'hd0, 8'h20};
    logic [1:0] r;
    TX_COUNT_WORD <= 16'h0047;
    for (int k = 0; k < 4; k++) begin
      if (k == 2) axw(pbf_pkg::PBF_REG_CTRL, 32'h1, 4'hf, r);
      TX_CTRL_BYTE <= cb[k];
      repeat (2) @(posedge MCLK);
      cmp("send length", 11'h040 + 11'(cb[k][5]), TX_SEND_LEN);
      cmp("append check", k != 3, TX_APPEND_CHECK);
    end
    TX_STATUS <= 16'h4001;
    TX_DONE <= 1'b1;
    @(posedge MCLK);
    TX_DONE <= 1'b0;
    repeat (3) @(posedge MCLK);
    cmp("tx status", 16'h4001, pbf_buf_mem_i.words[0]);
  endtask
  initial begin
    #3000000;
    fail_count++;
    end_sim();
  end
  initial begin
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {RX_START, RX_BYTE_VALID, RX_BYTE, RX_END, RX_ERR, RX_NIBBLE_ODD, RX_BIT_REM} = '0;
    {TX_COUNT_WORD, TX_CTRL_BYTE, TX_DONE, TX_STATUS} = '0;
    fail_count = 0;
    checks = 0;
    RST_B = 1'b0;
    repeat (2) @(posedge MCLK);
    RST_B <= 1'b1;
    @(posedge MCLK);
    t_regs();
    t_rx();
    t_tx();
    end_sim();
  end
endmodule // tb_top
